// *** src/lcd_pkg.sv ***
package lcd_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NUM_BUF = 20;
   localparam int NUM_SEG = 40;
   localparam int NUM_COM = 4;
   localparam int SUB_PER_PHASE = 32;

   // Register byte offsets
   localparam logic [7:0] OFS_CTL1 = 8'h00;
   localparam logic [7:0] OFS_CTL2 = 8'h04;
   localparam logic [7:0] OFS_MODEN = 8'h08;
   localparam logic [7:0] OFS_BUF0 = 8'h40;

   // panel_control_one fields
   localparam int DISP_EN_BIT = 7;
   localparam int DRIVE_LSB = 4;
   localparam int FREQ_LSB = 0;
   // panel_control_two fields
   localparam int SRC_SEL_BIT = 0;
   localparam int HIGHRES_BIT = 1;
   localparam int LRTIME_LSB = 3;
   localparam logic [7:0] CTL2_MASK = 8'h3b;
   // panel_module_enable_reg field
   localparam int MODEN_BIT = 0;

   localparam logic [7:0] CTL1_RST = 8'h00;
   localparam logic [7:0] CTL2_RST = 8'h00;
   localparam logic MODEN_RST = 1'b0;

   // Drive methods
   localparam logic [2:0] DRV_QUARTER = 3'h0;
   localparam logic [2:0] DRV_THIRD_B3 = 3'h1;
   localparam logic [2:0] DRV_THIRD_B2 = 3'h2;
   localparam logic [2:0] DRV_HALF = 3'h3;
   localparam logic [2:0] DRV_STATIC = 3'h4;

   // Base frequency codes and divider exponents per sub-phase strobe
   localparam logic [3:0] FREQ_SYS_LAST = 4'h4;
   localparam logic [3:0] FREQ_FAST_LAST = 4'h6;
   localparam logic [3:0] FREQ_FS9 = 4'h8;
   localparam logic [3:0] FREQ_FS8 = 4'h9;
   localparam int SYS_EXP0 = 11;
   localparam int FS9_EXP = 2;
   localparam int FS8_EXP = 1;

   localparam logic [2:0] LR_NEVER = 3'h0;
   localparam logic [2:0] LR_ALWAYS = 3'h6;

   function automatic logic freq_valid(logic [3:0] f);
      return (f <= FREQ_SYS_LAST) || (f == FREQ_FS9) || (f == FREQ_FS8);
   endfunction

   function automatic logic needs_slow(logic [3:0] f);
      return (f == FREQ_FS9) || (f == FREQ_FS8);
   endfunction

   // Phases per frame; static uses four so its frame equals the base rate
   function automatic logic [2:0] frame_phases(logic [2:0] d);
      case (d)
         DRV_THIRD_B3, DRV_THIRD_B2: return 3'h3;
         DRV_HALF: return 3'h2;
         default: return 3'h4;
      endcase
   endfunction
endpackage

// *** src/seg_buffer.sv ***
`timescale 1ns/1ps
module seg_buffer #(
   parameter int DEPTH = lcd_pkg::NUM_BUF,
   parameter int WIDTH = lcd_pkg::DATA_W,
   parameter int IDX_W = $clog2(DEPTH)
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Write port
   input wire logic wr_en,
   input wire logic [IDX_W-1:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   // Read port, data one cycle later
   input wire logic rd_en,
   input wire logic [IDX_W-1:0] rd_idx,
   output logic [WIDTH-1:0] rd_data,
   // Whole contents for the segment drivers
   output logic [DEPTH*WIDTH-1:0] contents
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0] rd;
   } buf_state_t;

   buf_state_t s;
   buf_state_t next_s;

   always_comb begin
      next_s = s;
      if (wr_en) begin
         next_s.mem[wr_idx] = wr_data;
      end
      next_s.rd = rd_en ? s.mem[rd_idx] : '0;
   end

   // All display data clears on reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rd_data = s.rd;
   assign contents = s.mem;
endmodule

// *** src/frame_timer.sv ***
`timescale 1ns/1ps
module frame_timer #(
   parameter int PRE_W = lcd_pkg::SYS_EXP0
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic [3:0] freq_sel,
   input wire logic low_speed_tick,
   // One pulse per thirty-second of a drive phase
   output logic sub_tick
);
   typedef struct packed {
      logic [PRE_W-1:0] pre;
      logic [1:0] slow;
      logic tick;
   } timer_state_t;

   timer_state_t s;
   timer_state_t next_s;

   function automatic logic low_ones(logic [PRE_W-1:0] v, int e);
      logic [PRE_W-1:0] m;
      m = PRE_W'((1 << e) - 1);
      return (v & m) == m;
   endfunction

   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (!run) begin
         next_s.pre = '0;
         next_s.slow = '0;
      end else begin
         next_s.pre = s.pre + 1'b1;
         if (low_speed_tick) begin
            next_s.slow = s.slow + 2'h1;
         end
         // Reserved codes give no strobe at all, never a stray rate
         if (freq_sel <= lcd_pkg::FREQ_SYS_LAST) begin
            next_s.tick = low_ones(s.pre,
               lcd_pkg::SYS_EXP0 - int'(freq_sel));
         end else if (freq_sel == lcd_pkg::FREQ_FS9) begin
            next_s.tick = low_speed_tick &&
               low_ones(PRE_W'(s.slow), lcd_pkg::FS9_EXP);
         end else if (freq_sel == lcd_pkg::FREQ_FS8) begin
            next_s.tick = low_speed_tick &&
               low_ones(PRE_W'(s.slow), lcd_pkg::FS8_EXP);
         end else begin
            next_s.tick = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sub_tick = s.tick;
endmodule

// *** src/segment_lcd_drive_control.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - display_enable closes the panel supply and drives; clear opens and blanks.
// - Commons low while display_enable is 0, common waveforms while 1.
// - Internal bleeder selected: bias pins freed for port use.
// - External bleeder selected: bias pins serve only as bleeder connections.
// - Shared segment pin is segment output when its function bit is 1.
// - Reset clears enable, supply off, commons low, segment pins high-Z.
// - SLEEP entered from SLOW with display on keeps pins and display running.
// - SLEEP entered from NORMAL blanks; only entry from SLOW keeps display.
// - STOP entry clears display_enable and blanks; software re-enables.
// - Module enable bit low blanks the display; high restores it.
// - Fast codes with fast clock stopped: bit reads 1, display blank.
// - Slow codes with slow clock stopped: bit reads 1, display blank.
// - Drive field selects 1/4, 1/3 (two biases), 1/2 duty or static.
// - Base rate is fsys over 2^18..2^14 or fs over 2^9, 2^8.
// - Frame rate: base for 1/4 and static, 4/3 for 1/3, 2x for 1/2.
// - Low resistance switch closes for a chosen time each drive period.
// - Connection code 000 keeps the low resistance switch open.
// - Code 110 keeps it closed; 001..101 give doubling fractions.
// - Buffer bit 1 lights its segment in its common phase; resets 0.
module segment_lcd_drive_control #(
   parameter int NUM_SEG = lcd_pkg::NUM_SEG
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port
   input wire logic [lcd_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [lcd_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [lcd_pkg::DATA_W-1:0] reg_rdata,
   // Operating mode and clock status
   input wire logic slow_mode,
   input wire logic sleep_mode,
   input wire logic stop_mode,
   input wire logic fast_clk_ready,
   input wire logic slow_clk_ready,
   input wire logic low_speed_tick,
   // Pin function selects
   input wire logic [NUM_SEG-1:0] port_function_bit,
   // Panel side
   output logic panel_supply_on,
   output logic [lcd_pkg::NUM_COM-1:0] com_out,
   output logic [NUM_SEG-1:0] seg_out,
   output logic [NUM_SEG-1:0] seg_oe,
   output logic low_res_switch,
   output logic high_res_value_select,
   output logic bias_ext_sel,
   output logic bias_port_release
);
   localparam int BUF_IDX_W = $clog2(lcd_pkg::NUM_BUF);
   localparam logic [4:0] SUB_LAST = 5'(lcd_pkg::SUB_PER_PHASE - 1);

   typedef struct packed {
      logic [7:0] ctl1;
      logic [7:0] ctl2;
      logic moden;
      logic [7:0] rdata;
      logic rd_buf;
      logic sleep_d;
      logic stop_d;
      logic sleep_blank;
      logic [1:0] phase;
      logic [4:0] sub;
      logic pol;
      logic supply;
      logic lrs;
      logic [lcd_pkg::NUM_COM-1:0] com;
      logic [NUM_SEG-1:0] seg;
      logic [NUM_SEG-1:0] oe;
   } ctl_state_t;

   ctl_state_t s;
   ctl_state_t next_s;

   function automatic logic buf_hit(logic [7:0] a);
      return (a >= lcd_pkg::OFS_BUF0) && (a[1:0] == 2'h0) &&
         (a < 8'(lcd_pkg::OFS_BUF0 + 4 * lcd_pkg::NUM_BUF));
   endfunction

   function automatic logic [BUF_IDX_W-1:0] buf_idx(logic [7:0] a);
      logic [7:0] d;
      d = a - lcd_pkg::OFS_BUF0;
      return d[BUF_IDX_W+1:2];
   endfunction

   logic [3:0] freq;
   logic [2:0] drive;
   logic [2:0] lr_code;
   logic is_static;
   logic [2:0] nph;
   logic clk_ok;
   logic run;
   logic sub_tick;
   logic buf_wr;
   logic buf_rd;
   logic [7:0] buf_rdata;
   logic [lcd_pkg::NUM_BUF*8-1:0] contents;
   logic [1:0] com_idx;
   logic lit;

   assign freq = s.ctl1[lcd_pkg::FREQ_LSB +: 4];
   assign drive = s.ctl1[lcd_pkg::DRIVE_LSB +: 3];
   assign lr_code = s.ctl2[lcd_pkg::LRTIME_LSB +: 3];
   assign is_static = (drive == lcd_pkg::DRV_STATIC);
   assign nph = lcd_pkg::frame_phases(drive);
   assign buf_wr = reg_wr && buf_hit(reg_addr);
   assign buf_rd = reg_rd && buf_hit(reg_addr);

   // The enable bit may read 1 while the chosen clock is absent
   always_comb begin
      if (freq <= lcd_pkg::FREQ_FAST_LAST) begin
         clk_ok = fast_clk_ready;
      end else if (lcd_pkg::needs_slow(freq)) begin
         clk_ok = slow_clk_ready;
      end else begin
         clk_ok = 1'b0;
      end
   end

   assign run = s.ctl1[lcd_pkg::DISP_EN_BIT] && s.moden && clk_ok &&
      !s.sleep_blank && lcd_pkg::freq_valid(freq);

   frame_timer u_timer (
      .mclk(mclk),
      .rst_n(rst_n),
      .run(run),
      .freq_sel(freq),
      .low_speed_tick(low_speed_tick),
      .sub_tick(sub_tick)
   );

   seg_buffer u_buf (
      .mclk(mclk),
      .rst_n(rst_n),
      .wr_en(buf_wr),
      .wr_idx(buf_idx(reg_addr)),
      .wr_data(reg_wdata),
      .rd_en(buf_rd),
      .rd_idx(buf_idx(reg_addr)),
      .rd_data(buf_rdata),
      .contents(contents)
   );

   always_comb begin
      next_s = s;
      com_idx = is_static ? 2'h0 : s.phase;
      lit = 1'b0;
      if (reg_wr) begin
         case (reg_addr)
            lcd_pkg::OFS_CTL1: next_s.ctl1 = reg_wdata;
            lcd_pkg::OFS_CTL2: next_s.ctl2 = reg_wdata & lcd_pkg::CTL2_MASK;
            lcd_pkg::OFS_MODEN: next_s.moden = reg_wdata[lcd_pkg::MODEN_BIT];
            default: next_s.moden = s.moden;
         endcase
      end
      next_s.rd_buf = buf_rd;
      next_s.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            lcd_pkg::OFS_CTL1: next_s.rdata = s.ctl1;
            lcd_pkg::OFS_CTL2: next_s.rdata = s.ctl2;
            lcd_pkg::OFS_MODEN: next_s.rdata = 8'(s.moden);
            default: next_s.rdata = '0;
         endcase
      end
      // STOP entry wins over a software set in the same cycle
      next_s.stop_d = stop_mode;
      if (stop_mode && !s.stop_d) begin
         next_s.ctl1[lcd_pkg::DISP_EN_BIT] = 1'b0;
      end
      next_s.sleep_d = sleep_mode;
      if (sleep_mode && !s.sleep_d) begin
         next_s.sleep_blank = !slow_mode;
      end else if (!sleep_mode) begin
         next_s.sleep_blank = 1'b0;
      end
      next_s.oe = port_function_bit;
      if (!run) begin
         next_s.supply = 1'b0;
         next_s.com = '0;
         next_s.seg = '0;
         next_s.phase = 2'h0;
         next_s.sub = 5'h0;
         next_s.pol = 1'b0;
         next_s.lrs = 1'b0;
      end else begin
         // Sleep from slow mode leaves run high, so pins keep going
         next_s.supply = 1'b1;
         if (sub_tick) begin
            next_s.sub = s.sub + 5'h1;
            if (s.sub == SUB_LAST) begin
               if (s.phase == 2'(nph - 3'h1)) begin
                  next_s.phase = 2'h0;
                  next_s.pol = !s.pol;
               end else begin
                  next_s.phase = s.phase + 2'h1;
               end
            end
         end
         for (int i = 0; i < lcd_pkg::NUM_COM; i++) begin
            if (is_static ? (i == 0) : (i < int'(nph))) begin
               next_s.com[i] = (2'(i) == com_idx) ? !s.pol : s.pol;
            end else begin
               next_s.com[i] = 1'b0;
            end
         end
         // A lit segment sits opposite its active common
         for (int j = 0; j < NUM_SEG; j++) begin
            lit = contents[(j / 2) * 8 + (j % 2) * 4 + int'(com_idx)];
            next_s.seg[j] = lit ? s.pol : !s.pol;
         end
         // Switch timing only matters for the internal chain
         if (!s.ctl2[lcd_pkg::SRC_SEL_BIT] || lr_code == lcd_pkg::LR_NEVER) begin
            next_s.lrs = 1'b0;
         end else if (lr_code >= lcd_pkg::LR_ALWAYS) begin
            next_s.lrs = (lr_code == lcd_pkg::LR_ALWAYS);
         end else begin
            // Use the coming sub count so the switch closes with the phase
            next_s.lrs = next_s.sub < (5'h1 << (lr_code - 3'h1));
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.ctl1 <= lcd_pkg::CTL1_RST;
         s.ctl2 <= lcd_pkg::CTL2_RST;
         s.moden <= lcd_pkg::MODEN_RST;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rd_buf ? buf_rdata : s.rdata;
   assign panel_supply_on = s.supply;
   assign com_out = s.com;
   assign seg_out = s.seg;
   assign seg_oe = s.oe;
   assign low_res_switch = s.lrs;
   assign high_res_value_select = s.ctl2[lcd_pkg::HIGHRES_BIT];
   assign bias_ext_sel = !s.ctl2[lcd_pkg::SRC_SEL_BIT];
   assign bias_port_release = s.ctl2[lcd_pkg::SRC_SEL_BIT];

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_com_low_off: assert property (!run |=> com_out == '0)
      else $error("commons not low while display blank");
   a_supply_on: assert property ($rose(run) |=> panel_supply_on)
      else $error("supply not closed after display start");
   a_stop_clear: assert property ($rose(stop_mode) |=>
      !s.ctl1[lcd_pkg::DISP_EN_BIT] ##1 !panel_supply_on)
      else $error("stop entry did not clear display enable");
   a_sleep_normal: assert property (sleep_mode && !s.sleep_d &&
      !slow_mode ##1 sleep_mode |=> !panel_supply_on)
      else $error("sleep from normal did not blank");
   a_sleep_slow: assert property (sleep_mode && !s.sleep_d && slow_mode &&
      run && !stop_mode && !reg_wr && $stable(slow_clk_ready) && $stable(fast_clk_ready)
      |=> run)
      else $error("sleep from slow stopped display");
   a_mod_off: assert property (!s.moden |=> !panel_supply_on)
      else $error("display active with module disabled");
   a_fast_missing: assert property (freq <= lcd_pkg::FREQ_FAST_LAST &&
      !fast_clk_ready |=> !panel_supply_on)
      else $error("display active without fast clock");
   a_slow_missing: assert property (lcd_pkg::needs_slow(freq) &&
      !slow_clk_ready |=> !panel_supply_on)
      else $error("display active without slow clock");
   a_lr_never: assert property (lr_code == lcd_pkg::LR_NEVER |=> !low_res_switch)
      else $error("low resistance closed with code zero");
   a_lr_always: assert property (run && s.ctl2[lcd_pkg::SRC_SEL_BIT] &&
      lr_code == lcd_pkg::LR_ALWAYS |=> low_res_switch)
      else $error("low resistance open with always code");
   a_reserved_quiet: assert property (!lcd_pkg::freq_valid(freq) |=> ##1 !sub_tick)
      else $error("strobe seen with reserved base code");
   a_oe_follow: assert property ($past(rst_n) |->
      seg_oe == $past(port_function_bit))
      else $error("segment enable does not follow function bits");

   c_display_run: cover property ($rose(panel_supply_on));
   c_phase_wrap: cover property (sub_tick && s.sub == SUB_LAST && s.phase == 2'h3);
   c_sleep_keep: cover property (sleep_mode && slow_mode && panel_supply_on);
   c_stop_entry: cover property ($rose(stop_mode) && panel_supply_on);
endmodule

// *** tb/lcd_panel_model.sv ***
`timescale 1ns/1ps
module lcd_panel_model #(
   parameter int NUM_SEG = 40
) (
   // Drive from the controller
   input wire logic mclk,
   input wire logic panel_supply_on,
   input wire logic [3:0] com_out,
   input wire logic [NUM_SEG-1:0] seg_out,
   input wire logic [NUM_SEG-1:0] seg_oe,
   // Pixel state seen against common zero, and dark panel
   output logic [NUM_SEG-1:0] lit,
   output logic blank
);
   // A pin left as a port floats, so it can never light its pixel
   always_ff @(posedge mclk) begin
      lit <= (seg_out ^ {NUM_SEG{com_out[0]}}) & seg_oe
         & {NUM_SEG{panel_supply_on}};
      blank <= !panel_supply_on && com_out == 4'h0;
   end
endmodule

// *** tb/segment_lcd_drive_control_bench.sv ***
`timescale 1ns/1ps
module segment_lcd_drive_control_bench;
   localparam logic [7:0] ctl1 = lcd_pkg::OFS_CTL1;
   localparam logic [7:0] ctl2 = lcd_pkg::OFS_CTL2;
   localparam logic [7:0] moden = lcd_pkg::OFS_MODEN;
   localparam logic [7:0] buf0 = lcd_pkg::OFS_BUF0;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic slow_mode = 1'b0;
   logic sleep_mode = 1'b0;
   logic stop_mode = 1'b0;
   logic fast_clk_ready = 1'b1;
   logic slow_clk_ready = 1'b1;
   logic low_speed_tick = 1'b0;
   logic [1:0] tcnt = 2'h0;
   logic [39:0] port_function_bit = 40'h0;
   logic [7:0] reg_rdata;
   logic [3:0] com_out, s0;
   logic [39:0] seg_out, seg_oe, lit;
   logic panel_supply_on, low_res_switch, high_res_value_select;
   logic bias_ext_sel, bias_port_release, blank;
   int err_total = 0;
   int n_checks = 0;
   int n, e;
   int np[5] = '{4, 3, 3, 2, 4};
   logic [3:0] mk[5] = '{4'hf, 4'h7, 4'h7, 4'h3, 4'h1};
   logic [3:0] fc[4] = '{4'h4, 4'h3, 4'h8, 4'h9};
   int pl[4] = '{4096, 8192, 512, 256};

   always #4 mclk = ~mclk;

   // Low-speed clock stand-in, one tick every four cycles
   always @(posedge mclk) begin
      tcnt <= tcnt + 2'h1;
      low_speed_tick <= (tcnt == 2'h3);
   end

   segment_lcd_drive_control segment_lcd_drive_control_inst (
      .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .slow_mode(slow_mode),
      .sleep_mode(sleep_mode), .stop_mode(stop_mode),
      .fast_clk_ready(fast_clk_ready), .slow_clk_ready(slow_clk_ready),
      .low_speed_tick(low_speed_tick),
      .port_function_bit(port_function_bit),
      .panel_supply_on(panel_supply_on), .com_out(com_out),
      .seg_out(seg_out), .seg_oe(seg_oe), .low_res_switch(low_res_switch),
      .high_res_value_select(high_res_value_select),
      .bias_ext_sel(bias_ext_sel), .bias_port_release(bias_port_release)
   );

   lcd_panel_model lcd_panel_model_inst (
      .mclk(mclk), .panel_supply_on(panel_supply_on), .com_out(com_out),
      .seg_out(seg_out), .seg_oe(seg_oe), .lit(lit), .blank(blank)
   );

   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [39:0] s,
         input logic [39:0] x);
      n_checks++;
      if (s !== x) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, x, s);
      end
   endtask

   task automatic sup(input logic x);
      chk("panel_supply_on", 40'(panel_supply_on), 40'(x));
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", 40'(reg_rdata), 40'(x));
   endtask

   // Cycles until the commons next change; bounded against a stall
   task automatic measure(output int cnt);
      logic [3:0] c;
      c = com_out;
      cnt = 0;
      while (com_out === c && cnt < 20000) begin
         tick(1);
         cnt++;
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      #600000;
      err_total++;
      conclude();
   end

   initial begin
      tick(16);
      sup(1'b0);
      chk("com_out", 40'(com_out), 40'h0);
      @(posedge mclk) rst_n <= 1'b1;
      tick(1);
      rd(ctl1, 8'h00);
      rd(moden, 8'h00);
      rd(8'h8c, 8'h00);
      wr(ctl2, 8'hff);
      rd(ctl2, lcd_pkg::CTL2_MASK);
      chk("release", 40'(bias_port_release), 40'h1);
      chk("ext_sel", 40'(bias_ext_sel), 40'h0);
      chk("high_res", 40'(high_res_value_select), 40'h1);
      wr(8'h0c, 8'h5a);
      rd(8'h0c, 8'h00);
      wr(8'h8c, 8'ha5);
      rd(8'h8c, 8'ha5);
      wr(buf0, 8'h21);
      @(posedge mclk) port_function_bit <= 40'h5a000000ff;
      tick(2);
      chk("seg_oe", seg_oe, 40'h5a000000ff);
      wr(moden, 8'h01);
      wr(ctl2, 8'h29);
      wr(ctl1, 8'h84);
      tick(1);
      sup(1'b1);
      chk("high_res", 40'(high_res_value_select), 40'h0);
      for (int i = 0; i < 4; i++) begin
         wr(ctl1, 8'h80 | 8'(fc[i]));
         measure(n);
         measure(n);
         chk("phase_len", 40'(n), 40'(pl[i]));
      end
      for (int d = 0; d < 5; d++) begin
         wr(ctl1, 8'h89 | 8'(d << 4));
         measure(n);
         measure(n);
         tick(128);
         s0 = com_out;
         tick(np[d] * 256);
         chk("frame", 40'(com_out & mk[d]), 40'(~s0 & mk[d]));
         chk("unused_com", 40'(com_out & ~mk[d]), 40'h0);
      end
      wr(ctl1, 8'h89);
      n = 0;
      while (!(com_out === 4'h1 || com_out === 4'he) && n < 2000) begin
         tick(1);
         n++;
      end
      tick(3);
      chk("lit", 40'(lit[1:0]), 40'h1);
      for (int c = 0; c < 8; c++) begin
         wr(ctl2, 8'(c << 3) | 8'h01);
         measure(n);
         measure(n);
         chk("sw_start", 40'(low_res_switch), 40'(c > 0 && c < 7));
         e = (c == 6) ? 256 : (c == 0 || c == 7) ? 0 : 8 << (c - 1);
         n = 0;
         repeat (256) begin
            n += int'(low_res_switch === 1'b1);
            tick(1);
         end
         chk("sw_time", 40'(n), 40'(e));
      end
      wr(ctl2, 8'h30);
      chk("ext_sel", 40'(bias_ext_sel), 40'h1);
      chk("release", 40'(bias_port_release), 40'h0);
      chk("low_res", 40'(low_res_switch), 40'h0);
      wr(moden, 8'h00);
      tick(2);
      sup(1'b0);
      chk("blank", 40'(blank), 40'h1);
      wr(moden, 8'h01);
      tick(1);
      sup(1'b1);
      for (int i = 0; i < 2; i++) begin
         wr(ctl1, 8'h00);
         @(posedge mclk);
         fast_clk_ready <= (i != 0);
         slow_clk_ready <= (i == 0);
         wr(ctl1, i ? 8'h88 : 8'h84);
         rd(ctl1, i ? 8'h88 : 8'h84);
         sup(1'b0);
         @(posedge mclk);
         fast_clk_ready <= 1'b1;
         slow_clk_ready <= 1'b1;
         tick(2);
         sup(1'b1);
      end
      for (int i = 5; i < 8; i += 2) begin
         wr(ctl1, 8'h80 | 8'(i));
         tick(2);
         sup(1'b0);
         chk("com_out", 40'(com_out), 40'h0);
      end
      // Display off around each mode switch; the fs code never changes
      wr(ctl1, 8'h09);
      @(posedge mclk) slow_mode <= 1'b1;
      wr(ctl1, 8'h89);
      @(posedge mclk) sleep_mode <= 1'b1;
      tick(4);
      sup(1'b1);
      chk("com_live", 40'(com_out != 4'h0), 40'h1);
      @(posedge mclk) sleep_mode <= 1'b0;
      wr(ctl1, 8'h09);
      @(posedge mclk) slow_mode <= 1'b0;
      wr(ctl1, 8'h89);
      @(posedge mclk) sleep_mode <= 1'b1;
      tick(2);
      sup(1'b0);
      @(posedge mclk) sleep_mode <= 1'b0;
      tick(2);
      sup(1'b1);
      @(posedge mclk) stop_mode <= 1'b1;
      tick(2);
      sup(1'b0);
      rd(ctl1, 8'h09);
      @(posedge mclk) stop_mode <= 1'b0;
      tick(2);
      sup(1'b0);
      wr(ctl1, 8'h89);
      tick(1);
      sup(1'b1);
      @(posedge mclk) rst_n <= 1'b0;
      tick(1);
      sup(1'b0);
      chk("com_out", 40'(com_out), 40'h0);
      chk("seg_oe", seg_oe, 40'h0);
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      tick(1);
      rd(ctl1, 8'h00);
      rd(buf0, 8'h00);
      conclude();
   end
endmodule
